//--- hdl/jtp_regs.svh
// How it works
// - IR and data paths share TDI and TDO
// - Only power-up reset forces Test-Logic-Reset
// - State holds while the test clock stops
// - TMS sampled at rising edge, steers state
// - Undriven TMS behaves as logic one
// - TDI sampled at rising edge, undriven is one
// - Uninverted delay equals selected register length
// - TDO changes only after falling edges
// - TDO driven only in shift states
// - TDO source switches at falling edge
// - Standard sixteen-state controller graph
// - State changes only on rising edge
// - Five TMS ones reach Test-Logic-Reset
// - Actions on assigned rising or falling edge
// - Communication only, no boundary-scan facilities
// - Controller states drive reset and debug
// - Latched instruction selects mode and path
// - Instruction scan shifts out captured status
// - Twelve cells, low bits capture 01
// - Update-IR falling edge loads parallel output
// - Test-Logic-Reset falling edge loads bypass
// - Shift IR in Shift-IR, hold in exit/pause
`ifndef JTP_REGS_SVH
`define JTP_REGS_SVH

// Register lengths
`define JTP_IR_LEN      12
`define JTP_DR_LEN      16
`define JTP_FIFO_DEPTH  8

// Instruction values
`define JTP_IR_BYPASS   12'hfff
`define JTP_IR_FIXED    2'h1
`define JTP_OP_FLASH    3'h1
`define JTP_OP_SCAN_RX  3'h2
`define JTP_OP_SCAN_TX  3'h3
`define JTP_OP_DBG_RST  3'h4
`define JTP_OP_ABORT_MK 3'h5
`define JTP_PID_ABORT   4'hf

// Flash sub-codes in instruction bits 11..3
`define JTP_FL_CTRL     9'h000
`define JTP_FL_ID       9'h001
`define JTP_FL_ADDR     9'h002
`define JTP_FL_READ     9'h006
`define JTP_FL_WRITE    9'h00a
`define JTP_FL_ERASE    9'h00e

`endif

//--- hdl/jtp_pkg.sv
package jtp_pkg;

  // Sixteen controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } jtp_state_t;

  // Tx/Rx link status captured during an instruction scan
  typedef struct packed {
    logic [4:0] msg_len;   // Tx message length in words
    logic [3:0] pid;       // Tx processor id, all ones when empty
    logic       rx_busy;   // Rx link busy
  } jtp_link_stat_t;

  // One scanned data word with the instruction that selected it
  typedef struct packed {
    logic [11:0] instr;
    logic [15:0] data;
  } jtp_word_t;

endpackage

//--- hdl/jtp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pins from outside the core clock domain
module jtp_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by the second

  // Plain register pair; reset loads a constant only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_q   <= INIT;
      sync_out <= INIT;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

//--- hdl/jtp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// Small synchronous FIFO with valid/ready on both sides
module jtp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage array
  logic [AW-1:0]    wr_q, wr_d;     // Write pointer
  logic [AW-1:0]    rd_q, rd_d;     // Read pointer
  localparam logic [AW:0] FULL_LVL = DEPTH[AW:0];  // Fill level when full

  logic [AW:0]      cnt_q, cnt_d;   // Fill level
  logic [WIDTH-1:0] head_q, head_d; // Word at the read pointer, registered
  logic             valid_q, valid_d; // Registered not-empty flag
  logic             push, pop;

  // Full flag from the fill level; the read side leaves from flip-flops
  assign in_ready  = (cnt_q != FULL_LVL);
  assign out_valid = valid_q;
  assign out_data  = head_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and level arithmetic; wrap for any depth
  always_comb begin
    wr_d  = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d  = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    valid_d = (cnt_d != '0);
    // A word pushed into the slot under the next read pointer skips memory
    head_d  = (push && (wr_q == rd_d)) ? in_data : mem_q[rd_d];
  end

  // Registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q   <= '0;
      head_q  <= '0;
      valid_q <= 1'b0;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      head_q  <= head_d;
      valid_q <= valid_d;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule

`default_nettype wire

//--- hdl/jtp_tap.sv
`timescale 1ns/1ps
`default_nettype none
`include "jtp_regs.svh"

// Test access port front end, sampled on the core clock.
// The test clock is treated as data: two flip-flops, then an edge finder,
// so every action lands two to three core cycles after its pin edge.
// Limitation: test clock phases shorter than one core cycle can be lost,
// which bounds the test clock to a few MHz at the 40 MHz core rate.
// Trade-off: one clock domain keeps timing simple at the cost of that limit.
module jtp_tap
  import jtp_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           reset,             // Power-up reset only
  input  wire logic           tck,               // Test clock pin
  input  wire logic           tms,               // Mode select pin, pulled up
  input  wire logic           tdi,               // Serial data pin, pulled up
  output logic                tdo,               // Serial data out
  output logic                tdo_oe,            // High while driving tdo
  input  wire jtp_link_stat_t link_stat,         // Tx/Rx link status
  input  wire logic [15:0]    dr_capture,        // Word loaded at Capture-DR
  output logic [11:0]         instr_out,         // Latched instruction
  output logic                test_reset,        // Controller in Test-Logic-Reset
  output logic                debug_reset,       // Device reset request
  output logic                debug_event_interrupt, // Debugger abort pulse
  output jtp_word_t           dr_word,           // Scanned word to flash/debug logic
  output logic                dr_word_valid,
  input  wire logic           dr_word_ready
);

  // Standard controller graph, one step per rising edge
  function automatic jtp_state_t jtp_next(input jtp_state_t s, input logic m);
    jtp_state_t n;
    n = s;
    unique case (s)
      // Reset and idle rows
      ST_RESET:    n = m ? ST_RESET : ST_IDLE;
      ST_IDLE:     n = m ? ST_SEL_DR : ST_IDLE;
      // Data register column
      ST_SEL_DR:   n = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: n = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   n = m ? ST_SEL_DR : ST_IDLE;
      // Instruction register column; five ones from anywhere end in reset
      ST_SEL_IR:   n = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:   n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: n = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   n = m ? ST_SEL_DR : ST_IDLE;
    endcase
    return n;
  endfunction

  // True when the instruction puts the 16-bit data path between TDI and TDO
  // Codes outside the table fall back to the one-cell bypass path
  function automatic logic jtp_uses_dr(input logic [11:0] ir);
    logic [8:0] hi;
    hi = ir[11:3];
    unique case (ir[2:0])
      `JTP_OP_SCAN_RX,
      `JTP_OP_SCAN_TX,
      `JTP_OP_ABORT_MK: jtp_uses_dr = 1'b1;
      // Flash codes use the data path only for the six known sub-codes
      `JTP_OP_FLASH:    jtp_uses_dr = (hi == `JTP_FL_CTRL)  || (hi == `JTP_FL_ID)   ||
                                      (hi == `JTP_FL_ADDR)  || (hi == `JTP_FL_READ) ||
                                      (hi == `JTP_FL_WRITE) || (hi == `JTP_FL_ERASE);
      default:          jtp_uses_dr = 1'b0;   // Bypass and reset request codes
    endcase
  endfunction

  // Pin inputs after two flip-flops each
  logic       tck_s;                 // Synchronised test clock
  logic       tms_s;                 // Synchronised mode select
  logic       tdi_s;                 // Synchronised serial input
  logic       tck_dly_q;             // Previous tck_s for edge finding
  logic       tck_rise;              // One core cycle per rising edge
  logic       tck_fall;              // One core cycle per falling edge

  // Controller and shift paths
  jtp_state_t st_q, st_d;            // Controller state
  logic [11:0] ir_sr_q, ir_sr_d;     // Instruction shift cells
  logic [11:0] ir_q, ir_d;           // Instruction parallel output
  logic [15:0] dr_sr_q, dr_sr_d;     // Data shift cells
  logic        byp_q, byp_d;         // One-cell bypass path

  // Serial output side
  logic        tdo_q, tdo_d;         // Output level
  logic        oe_q, oe_d;           // Output enable

  // Controls towards the flash and debugger logic
  logic        trst_q, trst_d;       // Test-Logic-Reset indication
  logic        drst_q, drst_d;       // Device reset request
  logic        abort_q, abort_d;     // Debugger abort pulse
  logic        push_q, push_d;       // Word offered to the FIFO
  jtp_word_t   word_q, word_d;       // Word held for the FIFO

  // Word queue and decode
  logic        fifo_ready;           // FIFO can take a word
  logic        dr_sel;               // Current instruction uses the data path

  // Level pins reset to one, as an undriven pulled-up pin reads
  // Only the second stage is read; the first may still be settling
  jtp_sync #(.WIDTH(3), .INIT(3'h6)) u_pin_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({tms, tdi, tck}),
    .sync_out ({tms_s, tdi_s, tck_s})
  );

  // Edges of the test clock; no edge means nothing moves
  // A rise and a fall are always at least one core cycle apart
  assign tck_rise = tck_s & ~tck_dly_q;
  assign tck_fall = ~tck_s & tck_dly_q;
  assign dr_sel   = jtp_uses_dr(ir_q);

  // Next values of the whole port, stepped by test clock edges
  // Rises move the controller and the shift cells, falls move tdo and
  // the instruction latch, so tdo never moves on a rise
  always_comb begin
    // Everything holds unless an edge moves it
    st_d    = st_q;
    ir_sr_d = ir_sr_q;
    ir_d    = ir_q;
    dr_sr_d = dr_sr_q;
    byp_d   = byp_q;
    tdo_d   = tdo_q;
    oe_d    = oe_q;
    // One-cycle strobes drop back unless an edge raises them
    abort_d = 1'b0;
    push_d  = 1'b0;
    word_d  = word_q;
    // Rising edge: TMS decides the move, shift cells act for the state left
    if (tck_rise) begin
      // Move decided by the mode select sampled at this rise
      st_d = jtp_next(st_q, tms_s);
      unique case (st_q)
        // Status goes out while the new instruction comes in
        ST_CAP_IR: begin
          ir_sr_d = {link_stat.msg_len, link_stat.pid,
                     link_stat.rx_busy | ~fifo_ready, `JTP_IR_FIXED};
        end
        // New bit enters at the top, bit 0 leaves toward tdo
        ST_SHIFT_IR: begin
          ir_sr_d = {tdi_s, ir_sr_q[11:1]};
        end
        // Selected register loads its word, the bypass cell loads zero
        ST_CAP_DR: begin
          if (dr_sel) begin
            dr_sr_d = dr_capture;
          end else begin
            byp_d = 1'b0;
          end
        end
        // Bypass delays one cell, the data path sixteen
        ST_SHIFT_DR: begin
          if (dr_sel) begin
            dr_sr_d = {tdi_s, dr_sr_q[15:1]};
          end else begin
            byp_d = tdi_s;
          end
        end
        default: begin
          // Exit and pause states hold every cell
        end
      endcase
    end
    // Falling edge: output routing, instruction latch and update actions
    if (tck_fall) begin
      // Driver on only while a shift state holds at this fall
      oe_d = (st_q == ST_SHIFT_IR) || (st_q == ST_SHIFT_DR);
      unique case (st_q)
        // Bit 0 of the instruction cells drives tdo
        ST_SHIFT_IR: begin
          tdo_d = ir_sr_q[0];
        end
        // Data path or bypass cell drives tdo
        ST_SHIFT_DR: begin
          tdo_d = dr_sel ? dr_sr_q[0] : byp_q;
        end
        // New code takes effect here, never during the shift
        ST_UPD_IR: begin
          ir_d = ir_sr_q;
          // Scan-Rx with an all-ones id is a debugger abort
          abort_d = (ir_sr_q[2:0] == `JTP_OP_SCAN_RX) &&
                    (ir_sr_q[6:3] == `JTP_PID_ABORT);
        end
        // Reloaded at every fall while resetting, so no code survives
        ST_RESET: begin
          ir_d = `JTP_IR_BYPASS;
        end
        ST_UPD_DR: begin
          // A full FIFO drops the word; RX busy warned the debugger
          if (dr_sel && fifo_ready) begin
            push_d = 1'b1;
            word_d = '{instr: ir_q, data: dr_sr_q};
          end
        end
        default: begin
          // Output keeps its last level while the driver is off
        end
      endcase
    end
  end

  // Controls that follow the controller state and instruction
  always_comb begin
    // High for every cycle the controller spends in Test-Logic-Reset
    trst_d = (st_d == ST_RESET);
    // Reset request follows the code in the cycle it is latched
    drst_d = (ir_d[2:0] == `JTP_OP_DBG_RST);
  end

  // Edge finder; reset leaves the pin looking low, its idle level
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tck_dly_q <= 1'b0;
    end else begin
      tck_dly_q <= tck_s;
    end
  end

  // Controller state; only the power-up reset reaches it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q   <= ST_RESET;
      trst_q <= 1'b1;
    end else begin
      st_q   <= st_d;
      trst_q <= trst_d;
    end
  end

  // Shift cells and the latched instruction; bypass is the power-up code
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ir_sr_q <= '0;
      ir_q    <= `JTP_IR_BYPASS;
      dr_sr_q <= '0;
      byp_q   <= 1'b0;
    end else begin
      ir_sr_q <= ir_sr_d;
      ir_q    <= ir_d;
      dr_sr_q <= dr_sr_d;
      byp_q   <= byp_d;
    end
  end

  // Serial output driver; off until the first shift state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
      oe_q  <= oe_d;
    end
  end

  // Controls towards the flash and debugger logic
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      drst_q  <= 1'b0;
      abort_q <= 1'b0;
      push_q  <= 1'b0;
      word_q  <= '0;
    end else begin
      drst_q  <= drst_d;
      abort_q <= abort_d;
      push_q  <= push_d;
      word_q  <= word_d;
    end
  end

  // Scanned words wait here for the flash and debugger logic
  // Eight words let a debugger stream a short burst while the core is busy
  jtp_fifo #(.WIDTH($bits(jtp_word_t)), .DEPTH(`JTP_FIFO_DEPTH)) u_word_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (push_q),
    .in_ready  (fifo_ready),
    .in_data   (word_q),
    .out_valid (dr_word_valid),
    .out_ready (dr_word_ready),
    .out_data  (dr_word)
  );

  // Registered outputs; no boundary-scan cells exist here
  // Every pin and flag below is a flip-flop, so no decode glitch leaves
  assign tdo                   = tdo_q;
  assign tdo_oe                = oe_q;
  assign instr_out             = ir_q;
  assign test_reset            = trst_q;
  assign debug_reset           = drst_q;
  assign debug_event_interrupt = abort_q;

endmodule

`default_nettype wire

//--- sim/jtp_jtag_host.sv
`timescale 1ns/1ps
`default_nettype none

// Bus controller model; its test clock rests low between frames
module jtp_jtag_host (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic tms_v;      // Driven mode level
  logic tdi_v;      // Driven data level
  logic drv;        // High while the pins are driven
  int   half = 100; // Half period in ns, raised for a slow controller

  // Released pins float to their pull-ups
  assign tms = drv ? tms_v : 1'b1;
  assign tdi = drv ? tdi_v : 1'b1;
  initial tck = 1'b0;
  initial drv = 1'b0;

  // One clock; tdo is read at the rise, and an undriven tdo reads inverted
  task automatic step(input logic m, input logic d, input logic en, output logic o);
    drv   = en;
    tms_v = m;
    tdi_v = d;
    #(half);
    o   = tdo_oe ? tdo : ~tdo;
    tck = 1'b1;
    #(half);
    tck = 1'b0;
  endtask

  // Idle to idle through one scan; bit 0 leaves first
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic o;
    dout = 16'h0000;
    step(1'b1, 1'b1, 1'b1, o);
    if (ir) begin
      step(1'b1, 1'b1, 1'b1, o);
    end
    step(1'b0, 1'b1, 1'b1, o);
    step(1'b0, 1'b1, 1'b1, o);
    // Captured bits come out while the new vector goes in
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], 1'b1, o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, 1'b1, o);
    step(1'b0, 1'b1, 1'b1, o);
  endtask
endmodule

`default_nettype wire

//--- sim/jtp_tap_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Port checker for the test access port front end
module jtp_tap_assertions
  import jtp_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        tck,
  input wire logic        tdo,
  input wire logic        tdo_oe,
  input wire logic [11:0] instr_out,
  input wire logic        test_reset,
  input wire logic        debug_reset,
  input wire logic        debug_event_interrupt,
  input wire jtp_word_t   dr_word,
  input wire logic        dr_word_valid,
  input wire logic        dr_word_ready
);
  logic       tck_q;   // Pin level at the last edge
  logic [3:0] fall_q;  // Cycles since the pin fell, saturating
  logic [3:0] fall_d;
  logic [3:0] still_q; // Cycles the pin has not moved, saturating
  logic [3:0] still_d;

  // Still age restarts at any pin edge, fall age at falls only; saturation keeps long pauses harmless
  always_comb begin
    fall_d  = (fall_q == 4'hf) ? fall_q : fall_q + 4'h1;
    still_d = (still_q == 4'hf) ? still_q : still_q + 4'h1;
    if (tck_q && !tck) begin
      fall_d = 4'h0;
    end
    if (tck_q != tck) begin
      still_d = 4'h0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tck_q   <= 1'b0;
      fall_q  <= 4'hf;
      still_q <= 4'h0;
    end else begin
      tck_q   <= tck;
      fall_q  <= fall_d;
      still_q <= still_d;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_abort_code;
    instr_out[6:0] == 7'h7a;
  endsequence

  a_oe_off_reset: assert property (test_reset |-> !tdo_oe)
    else $error("tdo driven in test-logic-reset");
  a_out_after_fall: assert property (
    ($changed(tdo) || $changed(tdo_oe) || $changed(instr_out)) |-> fall_q <= 4'h5)
    else $error("output moved away from a falling test clock");
  a_hold_stopped: assert property (still_q >= 4'h8 |->
    $stable(tdo) && $stable(tdo_oe) && $stable(instr_out) && $stable(test_reset))
    else $error("state moved while the test clock stood still");
  a_bypass_on_reset: assert property (
    $rose(test_reset) |-> ##[1:40] instr_out == 12'hfff)
    else $error("bypass not latched in test-logic-reset");
  a_reset_decode: assert property (debug_reset == (instr_out[2:0] == 3'h4))
    else $error("device reset request disagrees with instruction");
  a_abort_pulse: assert property (debug_event_interrupt |=> !debug_event_interrupt)
    else $error("abort pulse longer than one cycle");
  a_abort_code: assert property (debug_event_interrupt |-> ##[0:1] s_abort_code)
    else $error("abort pulse without its instruction");
  a_fifo_hold: assert property (
    dr_word_valid && !dr_word_ready |=> dr_word_valid && $stable(dr_word))
    else $error("queued word lost before it was taken");
endmodule

bind jtp_tap jtp_tap_assertions chk_u (
  .core_clk(core_clk), .reset(reset), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
  .instr_out(instr_out), .test_reset(test_reset), .debug_reset(debug_reset),
  .debug_event_interrupt(debug_event_interrupt), .dr_word(dr_word),
  .dr_word_valid(dr_word_valid), .dr_word_ready(dr_word_ready));

`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

// Random scans through every instruction kind, then a FIFO drain
module tb
  import jtp_pkg::*;
;
  logic           core_clk;
  logic           reset;
  logic           tck;
  logic           tms;
  logic           tdi;
  logic           tdo;
  logic           tdo_oe;
  jtp_link_stat_t link_stat;  // Status seen by IR capture
  logic [15:0]    dr_capture; // Word seen by DR capture
  logic [11:0]    instr_out;
  logic           test_reset;
  logic           debug_reset;
  logic           debug_event_interrupt;
  jtp_word_t      dr_word;
  logic           dr_word_valid;
  logic           dr_word_ready;
  logic           irq_seen;   // Abort pulse caught
  logic           b;          // Discarded bit
  logic [11:0]    v;          // Instruction under test
  int             err_total;
  int             check_count;
  int             seed;
  jtp_word_t      q[$];       // Words the FIFO should hold

  jtp_jtag_host host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  jtp_tap dut_u (
    .core_clk(core_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .link_stat(link_stat), .dr_capture(dr_capture),
    .instr_out(instr_out), .test_reset(test_reset), .debug_reset(debug_reset),
    .debug_event_interrupt(debug_event_interrupt), .dr_word(dr_word),
    .dr_word_valid(dr_word_valid), .dr_word_ready(dr_word_ready));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // The abort pulse lasts one cycle, so it is latched here
  always @(posedge core_clk) begin
    if (debug_event_interrupt === 1'b1) begin
      irq_seen <= 1'b1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Instructions that put the 16-bit word between tdi and tdo
  function automatic logic sel(input logic [11:0] c);
    case (c[2:0])
      3'h2, 3'h3, 3'h5: return 1'b1;
      3'h1: return c[11:3] inside {9'h000, 9'h001, 9'h002, 9'h006, 9'h00a, 9'h00e};
      default: return 1'b0;
    endcase
  endfunction

  // IR scan of v; status comes back, then v must be latched
  task automatic ir();
    logic [15:0] o;
    logic [11:0] e;
    @(posedge core_clk);
    #2;
    link_stat = 10'($random(seed));
    irq_seen  = 1'b0;
    host_u.scan(1'b1, 12, {4'h0, v}, o);
    e = {link_stat.msg_len, link_stat.pid, link_stat.rx_busy | (q.size() == 8), 2'b01};
    check("capture", o[11:0], e);
    check("instr", instr_out, v);
    check("dbg_rst", debug_reset, v[2:0] == 3'h4);
    check("abort", irq_seen, v[6:0] == 7'h7a);
  endtask

  // DR scan; bypass delays one cell and captures zero, a full FIFO drops
  task automatic dr();
    logic [15:0] o;
    logic [15:0] d;
    d = 16'($random(seed));
    @(posedge core_clk);
    #2;
    dr_capture = 16'($random(seed));
    host_u.scan(1'b0, 16, d, o);
    check("dr_out", o, sel(v) ? dr_capture : {d[14:0], 1'b0});
    if (sel(v) && q.size() < 8) begin
      q.push_back({v, d});
    end
  endtask

  initial begin
    seed          = 32'h7ac90074;
    reset         = 1'b1;
    link_stat     = '0;
    dr_capture    = 16'h0000;
    dr_word_ready = 1'b0;
    irq_seen      = 1'b0;
    err_total     = 0;
    check_count   = 0;
    repeat (4) @(posedge core_clk);
    #2;
    check("reset", {test_reset, tdo_oe, dr_word_valid, debug_reset, instr_out},
          {4'h8, 12'hfff});
    reset = 1'b0;
    repeat (4) @(posedge core_clk);
    #2;
    host_u.step(1'b0, 1'b1, 1'b1, b);
    // Every code kind once, random don't-care bits; consumer stalls throughout
    for (int i = 0; i < 14; i++) begin
      v = 12'($random(seed));
      case (i)
        0: v = 12'h001;
        1: v = 12'h009;
        2: v = 12'h011;
        3: v = 12'h031;
        4: v = 12'h051;
        5: v = 12'h071;
        6: v[2:0] = 3'h2;
        7: v[6:0] = 7'h7a;
        8: v[2:0] = 3'h3;
        9: v[2:0] = 3'h5;
        10: v[2:0] = 3'h7;
        11: v[2:0] = 3'h0;
        12: v = 12'h0f9;
        default: v[2:0] = 3'h4;
      endcase
      host_u.half = (i == 3) ? 300 : 100;
      ir();
      dr();
    end
    // Park in Shift-IR with the clock stopped, then float both pins
    host_u.step(1'b1, 1'b1, 1'b1, b);
    host_u.step(1'b1, 1'b1, 1'b1, b);
    host_u.step(1'b0, 1'b1, 1'b1, b);
    host_u.step(1'b0, 1'b1, 1'b1, b);
    repeat (80) @(posedge core_clk);
    #2;
    check("parked", {tdo_oe, tdo, instr_out}, {2'b11, v});
    repeat (5) host_u.step(1'b0, 1'b0, 1'b0, b);
    repeat (6) @(posedge core_clk);
    #9;
    check("floated", {test_reset, debug_reset, instr_out}, {2'b10, 12'hfff});
    // Drain with a consumer that stalls at random
    for (int k = 0; k < 400 && q.size() > 0; k++) begin
      @(posedge core_clk);
      #2;
      dr_word_ready = 1'($random(seed));
      if (dr_word_ready && dr_word_valid === 1'b1) begin
        check("word", dr_word, q.pop_front());
      end
    end
    repeat (3) @(posedge core_clk);
    #2;
    check("drained", {q.size() == 0, dr_word_valid}, 2'b10);
    complete_run();
  end

  // Watchdog at roughly fifteen times the expected run
  initial begin
    #2_000_000;
    err_total++;
    complete_run();
  end
endmodule

`default_nettype wire
